// ===== rtl/tx_silence_ctrl.sv
// Transmit-silence test mode control with swing strap and register file.
// Assumes an AXI4-Lite master on sys_clk and a synchronous strap pin.
//
// Notes on behaviour
// - Readable power-down done status bit.
// - Clearing power-down once done resumes in chosen configuration.
// - Silence mode keeps paths running, sends zeros.
// - Strap high restricts transmitter to 1.0 V.
// - Strap low allows 2.4 V, lower selectable.
`timescale 1ns/1ps
`default_nettype none
module tx_silence_ctrl
  import tx_silence_pkg::*;
#(
  parameter int SYM_W = 2
)
(
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             high_swing_strap,
  input  wire logic [SYM_W-1:0] tx_symbol_in,
  output logic [SYM_W-1:0]      tx_symbol_out,
  output logic                  tx_path_enable,
  output logic                  rx_path_enable,
  output logic                  tx_high_swing,
  output logic                  autoneg_enable,
  output logic                  autoneg_forced_cfg
);

  // ==========================================================
  // Reset synchroniser
  logic rst_meta_r;
  logic rst_n_r;

  // Asynchronous assert, synchronous release
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ==========================================================
  // Strap capture
  logic strap_value;
  logic strap_valid;

  strap_capture u_strap (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n_r),
    .strap_in    (high_swing_strap),
    .strap_value (strap_value),
    .strap_valid (strap_valid)
  );

  // ==========================================================
  // AXI4-Lite slave and control registers
  logic             aw_held_r,  aw_held_nxt;
  logic [7:0]       aw_addr_r,  aw_addr_nxt;
  logic             w_held_r,   w_held_nxt;
  logic [31:0]      w_data_r,   w_data_nxt;
  logic             w_strb_r,   w_strb_nxt;
  logic             bvalid_r,   bvalid_nxt;
  logic [1:0]       bresp_r,    bresp_nxt;
  logic             rvalid_r,   rvalid_nxt;
  logic [31:0]      rdata_r,    rdata_nxt;
  logic [1:0]       rresp_r,    rresp_nxt;
  logic             pd_req_r,   pd_req_nxt;
  logic             autoneg_enable_r,    autoneg_enable_nxt;
  logic             an_frc_r,   an_frc_nxt;
  logic             low_sel_r,  low_sel_nxt;
  logic [1:0]       silence_r,  silence_nxt;
  logic             do_write;
  logic [31:0]      status_word;

  logic             pd_done;
  logic             silent_active;
  logic             running;

  // One of each address and data may wait; write fires when both held
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;

  // Status word built from live block state
  always_comb
  begin
    status_word = 32'h0;
    status_word[STAT_PD_DONE_BIT]  = pd_done;
    status_word[STAT_STRAP_BIT]    = strap_value;
    status_word[STAT_HIGH_SEL_BIT] = tx_high_swing;
    status_word[STAT_SILENT_BIT]   = silent_active;
    status_word[STAT_RUNNING_BIT]  = running;
  end

  // Bus handshakes and register writes
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    pd_req_nxt  = pd_req_r;
    autoneg_enable_nxt   = autoneg_enable_r;
    an_frc_nxt  = an_frc_r;
    low_sel_nxt = low_sel_r;
    silence_nxt = silence_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb[0]; // All fields live in byte 0
    end
    if (do_write)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      unique case (aw_addr_r)
        CTRL_OFFSET:
          if (w_strb_r)
            pd_req_nxt = w_data_r[CTRL_PD_REQ_BIT];
        AUTONEG_OFFSET:
          if (w_strb_r)
          begin
            autoneg_enable_nxt   = w_data_r[AN_ENABLE_BIT];
            an_frc_nxt  = w_data_r[AN_FORCED_BIT];
            low_sel_nxt = w_data_r[AN_LOW_SWING_BIT];
          end
        TEST_OFFSET:
          if (w_strb_r)
            silence_nxt = w_data_r[TEST_SILENCE_LSB +: TEST_SILENCE_W];
        STATUS_OFFSET: ; // Read only, write ignored
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    else if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFFSET:    rdata_nxt = {31'h0, pd_req_r};
        AUTONEG_OFFSET: rdata_nxt = {29'h0, low_sel_r, an_frc_r, autoneg_enable_r};
        TEST_OFFSET:    rdata_nxt = {30'h0, silence_r};
        STATUS_OFFSET:  rdata_nxt = status_word;
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OKAY;
      pd_req_r  <= PD_REQ_RST;
      autoneg_enable_r   <= AN_ENABLE_RST;
      an_frc_r  <= AN_FORCED_RST;
      low_sel_r <= LOW_SWING_RST;
      silence_r <= SILENCE_RST;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r  <= w_held_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      pd_req_r  <= pd_req_nxt;
      autoneg_enable_r   <= autoneg_enable_nxt;
      an_frc_r  <= an_frc_nxt;
      low_sel_r <= low_sel_nxt;
      silence_r <= silence_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ==========================================================
  // Power-down sequencing
  pwr_state_t pwr_r, pwr_nxt;
  logic [7:0] settle_r, settle_nxt;
  logic       silence_live_r, silence_live_nxt;

  // Done is only reported after the settle count has run out
  always_comb
  begin
    pwr_nxt          = pwr_r;
    settle_nxt       = settle_r;
    silence_live_nxt = silence_live_r;
    unique case (pwr_r)
      PWR_RUN:
        if (pd_req_r)
        begin
          pwr_nxt    = PWR_ENTERING;
          settle_nxt = 8'(PD_SETTLE_CYCLES - 1);
        end
      PWR_ENTERING:
        if (!pd_req_r)
          pwr_nxt = PWR_RUN;
        else if (settle_r == 8'h00)
          pwr_nxt = PWR_DOWN;
        else
          settle_nxt = settle_r - 8'h01;
      PWR_DOWN:
        if (!pd_req_r)
        begin
          pwr_nxt          = PWR_RUN;
          // Mode is taken only with autoneg off and forced
          silence_live_nxt = (silence_r == SILENCE_ON) && !autoneg_enable_r
                             && an_frc_r;
        end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pwr_r          <= PWR_RUN;
      settle_r       <= 8'h00;
      silence_live_r <= 1'b0;
    end
    else
    begin
      pwr_r          <= pwr_nxt;
      settle_r       <= settle_nxt;
      silence_live_r <= silence_live_nxt;
    end
  end

  assign pd_done       = (pwr_r == PWR_DOWN);
  assign running       = (pwr_r == PWR_RUN);
  assign silent_active = silence_live_r && running;

  // ==========================================================
  // Datapath outputs
  logic [SYM_W-1:0] sym_r, sym_nxt;
  logic             high_r, high_nxt;

  // Paths stay live in silence mode; only the symbols go to zero
  always_comb
  begin
    sym_nxt  = silent_active ? '0 : tx_symbol_in;
    // Strap high forbids the high swing outright
    high_nxt = strap_valid && !strap_value
               && !low_sel_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      sym_r  <= '0;
      high_r <= 1'b0;
    end
    else
    begin
      sym_r  <= sym_nxt;
      high_r <= high_nxt;
    end
  end

  assign tx_symbol_out      = running ? sym_r : '0;
  assign tx_path_enable     = running;
  assign rx_path_enable     = running;
  assign tx_high_swing      = high_r;
  assign autoneg_enable     = autoneg_enable_r;
  assign autoneg_forced_cfg = an_frc_r;

endmodule
`default_nettype wire

// ===== rtl/tx_silence_pkg.sv
// Shared constants for the transmit-silence test mode control block.
// Assumes a 40 MHz core clock and 32-bit AXI4-Lite register access.
package tx_silence_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] AUTONEG_OFFSET = 8'h04;
  localparam logic [7:0] TEST_OFFSET    = 8'h08;
  localparam logic [7:0] STATUS_OFFSET  = 8'h0c;

  // ==========================================================
  // Field positions
  localparam int CTRL_PD_REQ_BIT   = 0;
  localparam int AN_ENABLE_BIT     = 0;
  localparam int AN_FORCED_BIT     = 1;
  localparam int AN_LOW_SWING_BIT  = 2;
  localparam int TEST_SILENCE_LSB  = 0;
  localparam int TEST_SILENCE_W    = 2;
  localparam int STAT_PD_DONE_BIT  = 0;
  localparam int STAT_STRAP_BIT    = 1;
  localparam int STAT_HIGH_SEL_BIT = 2;
  localparam int STAT_SILENT_BIT   = 3;
  localparam int STAT_RUNNING_BIT  = 4;

  // ==========================================================
  // Reset values, and the silence-on code
  localparam logic       PD_REQ_RST     = 1'b0;
  localparam logic       AN_ENABLE_RST  = 1'b1;
  localparam logic       AN_FORCED_RST  = 1'b0;
  localparam logic       LOW_SWING_RST  = 1'b0;
  localparam logic [1:0] SILENCE_RST    = 2'h0;
  localparam logic [1:0] SILENCE_ON     = 2'h3;

  // ==========================================================
  // Timing: power-down settle time in ns, and derived cycles
  localparam int CLK_PERIOD_NS    = 25;
  localparam int PD_SETTLE_NS     = 200;
  localparam int PD_SETTLE_CYCLES =
    (PD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power state machine
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_ENTERING,
    PWR_DOWN
  } pwr_state_t;

endpackage

// ===== rtl/strap_capture.sv
// Strap latch: samples the swing strap once after reset release.
// Assumes the strap pin is static and synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module strap_capture
  import tx_silence_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic strap_in,
  output logic      strap_value,
  output logic      strap_valid
);

  logic taken_r;
  logic taken_nxt;
  logic value_r;
  logic value_nxt;

  // ==========================================================
  // Capture
  // Take the pin once, at the first edge after release
  always_comb
  begin
    taken_nxt = 1'b1;
    value_nxt = taken_r ? value_r : strap_in;
  end

  // Reset loads constants only; the pin is read after release
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      taken_r <= 1'b0;
      value_r <= 1'b1;   // Safe low-swing until sampled
    end
    else
    begin
      taken_r <= taken_nxt;
      value_r <= value_nxt;
    end
  end

  assign strap_value = value_r;
  assign strap_valid = taken_r;

endmodule
`default_nettype wire

// ===== verif/tx_silence_assertions.sv
// Port checker for the transmit-silence control block.
// Assumes one sys_clk domain; bound onto tx_silence_ctrl below.
`timescale 1ns/1ps
`default_nettype none
module tx_silence_assertions #(
  parameter int SYM_W = 2
)
(
  input wire logic             sys_clk,
  input wire logic             reset_n,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic             high_swing_strap,
  input wire logic [SYM_W-1:0] tx_symbol_out,
  input wire logic             tx_path_enable,
  input wire logic             rx_path_enable,
  input wire logic             tx_high_swing
);
  // ==========================================================
  // Properties, all on sys_clk and cut off by reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  paths_together_a: assert property (
    tx_path_enable == rx_path_enable)
    else $error("path enables differ");
  strap_high_a: assert property (
    high_swing_strap [*8] |-> !tx_high_swing)
    else $error("high swing chosen with strap high");
  idle_zero_a: assert property (
    !tx_path_enable [*2] |-> tx_symbol_out == '0)
    else $error("symbols sent while stopped");
  // Both halves are held for one edge, and the answer rises on the next
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");

  // Main scenarios reached
  cover property (!tx_path_enable);
  cover property (tx_path_enable [*4] ##0 tx_symbol_out == '0);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind tx_silence_ctrl tx_silence_assertions #(.SYM_W(SYM_W)) chk (.*);
`default_nettype wire

// ===== verif/sym_source.sv
// Transmit datapath stand-in that feeds symbols into the block.
// Assumes sys_clk and an active-low reset; never emits a zero symbol.
`timescale 1ns/1ps
`default_nettype none
module sym_source
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  output logic [1:0] sym
);
  // ==========================================================
  // Cycle 1,2,3 so a zero at the output while running can only come from silencing
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      sym <= 2'h1;
    else
      sym <= (sym == 2'h3) ? 2'h1 : sym + 2'h1;
endmodule
`default_nettype wire

// ===== verif/tx_silence_ctrl_tb_top.sv
// Self-checking bench: AXI4-Lite host walking the silence entry sequence.
// Assumes the design answers every bus request; a cycle ceiling guards.
`timescale 1ns/1ps
`default_nettype none
module tx_silence_ctrl_tb_top
  import tx_silence_pkg::*;
;
  logic sys_clk = 0, reset_n = 0, high_swing_strap = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, tx_high_swing, autoneg_enable;
  logic tx_path_enable, rx_path_enable, autoneg_forced_cfg;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, tx_symbol_in, tx_symbol_out;
  int errors = 0, n_compared = 0, cycles = 0;

  tx_silence_ctrl dut (.*);
  sym_source src (.sys_clk(sys_clk), .reset_n(reset_n),
                  .sym(tx_symbol_in));

  always #12.5 sys_clk = ~sys_clk;

  // ==========================================================
  // Helpers; a hung handshake is cut off by the cycle ceiling
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic do_reset(input logic strap);
    @(posedge sys_clk);
    reset_n <= 1'h0;
    high_swing_strap <= strap;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
  endtask

  // Readies and answers are taken as sampled at the rising edge itself
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic da, dw;
    da = 0;
    dw = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(da && dw))
    begin
      @(posedge sys_clk);
      if (s_axi_awready) da = 1;
      if (s_axi_wready) dw = 1;
      if (da) s_axi_awvalid <= 1'h0;
      if (dw) s_axi_wvalid <= 1'h0;
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Power down and wait for the done flag, seen low at first
  task automatic power_down();
    wr(CTRL_OFFSET, 32'h1);
    rd(STATUS_OFFSET);
    chk("pd done early", v[STAT_PD_DONE_BIT], 1'h0);
    do rd(STATUS_OFFSET); while (v[STAT_PD_DONE_BIT] !== 1'h1);
    chk("paths stopped", tx_path_enable, 1'h0);
  endtask

  task automatic sym_chk(input logic zero);
    repeat (4)
    begin
      @(negedge sys_clk);
      chk("zero symbol", tx_symbol_out == 2'h0, zero);
    end
  endtask

  // ==========================================================
  // Test sequence
  initial
  begin
    do_reset(1'h0);
    rd(AUTONEG_OFFSET);
    chk("autoneg reset", v, 32'h1);
    rd(STATUS_OFFSET);
    chk("status reset", v, 32'h14);
    $display("test reset values done");
    wr(AUTONEG_OFFSET, 32'h5);
    repeat (2) @(posedge sys_clk);
    chk("low swing", tx_high_swing, 1'h0);
    wr(AUTONEG_OFFSET, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("high swing", tx_high_swing, 1'h1);
    $display("test swing select done");
    rd(8'h10);
    chk("unmapped resp", r, RESP_SLVERR);
    chk("unmapped data", v, 32'h0);
    wr(STATUS_OFFSET, 32'h0);
    chk("status write", r, RESP_OKAY);
    wr(8'h14, 32'h1);
    chk("unmapped write", r, RESP_SLVERR);
    $display("test refusals done");
    // Late bready: the write answer must stand until it is taken
    @(posedge sys_clk);
    s_axi_awaddr <= TEST_OFFSET;
    s_axi_wdata <= 32'h0;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    repeat (3) @(posedge sys_clk);
    s_axi_bready <= 1'h1;
    @(posedge sys_clk);
    chk("stalled bvalid", s_axi_bvalid, 1'h1);
    chk("stalled bresp", s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'h0;
    // Late rready: the read data must stand until it is taken
    @(posedge sys_clk);
    s_axi_araddr <= AUTONEG_OFFSET;
    s_axi_arvalid <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    repeat (3) @(posedge sys_clk);
    s_axi_rready <= 1'h1;
    @(posedge sys_clk);
    chk("stalled rvalid", s_axi_rvalid, 1'h1);
    chk("stalled rdata", s_axi_rdata, 32'h1);
    s_axi_rready <= 1'h0;
    $display("test stalled answers done");
    power_down();
    wr(AUTONEG_OFFSET, 32'h0);
    chk("autoneg off", autoneg_enable, 1'h0);
    wr(AUTONEG_OFFSET, 32'h2);
    chk("autoneg forced", autoneg_forced_cfg, 1'h1);
    chk("autoneg still off", autoneg_enable, 1'h0);
    wr(TEST_OFFSET, 32'h3);
    wr(CTRL_OFFSET, 32'h0);
    rd(STATUS_OFFSET);
    chk("silent status", v, 32'h1c);
    chk("paths running", rx_path_enable, 1'h1);
    sym_chk(1'h1);
    $display("test silence entry done");
    wr(TEST_OFFSET, 32'h0);
    power_down();
    wr(CTRL_OFFSET, 32'h0);
    rd(STATUS_OFFSET);
    chk("normal status", v, 32'h14);
    sym_chk(1'h0);
    $display("test silence exit done");
    do_reset(1'h1);
    chk("strap high", tx_high_swing, 1'h0);
    rd(STATUS_OFFSET);
    chk("strap status", v, 32'h12);
    high_swing_strap <= 1'h0;
    wr(AUTONEG_OFFSET, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk("strap held", tx_high_swing, 1'h0);
    $display("test strap done");
    finish_test();
  end
endmodule
`default_nettype wire
